// file: inc/bch_pkg.sv
// Constants, types and Galois-field arithmetic for the BCH stream decoder.
package bch_pkg;

  // Code geometry.
  localparam int M         = 14;
  localparam int T         = 40;
  localparam int N         = 8784;    // R14
  localparam int D         = 20;      // R20
  localparam int PARITY    = M * T;   // R17
  localparam int K         = N - PARITY; // R18
  localparam int NSYN      = 2 * T;
  localparam int LEN       = T + 2;
  localparam int GF_ORDER  = (1 << M) - 1;
  localparam int M_MIN_DEC = 6;
  localparam int M_MAX     = 14;
  localparam int T_MIN_DEC = 8;
  localparam int T_MAX_DEC = 127;

  // Field generator x^14+x^10+x^6+x+1.
  localparam logic [M:0] PRIM_POLY = 15'h4443; // R19

  // Stream framing and storage.
  localparam int WORDS    = (N + D - 1) / D;
  localparam int REM_BITS = N - (WORDS - 1) * D;
  localparam int NBANK    = 3;
  localparam int AW       = $clog2(NBANK * WORDS);
  localparam int WW       = $clog2(WORDS);
  localparam int ERRW     = $clog2(T + 1) + 1;
  localparam int LW       = 8;

  // Register map.
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] LAST_OFS     = 8'h08;
  localparam int         CTRL_CORR    = 0;
  localparam logic       CTRL_RESET   = 1'h1;
  localparam int         STAT_BAD_LSB = 16;
  localparam int         LAST_BAD_BIT = 16;

  typedef logic [M-1:0] bch_sym_t;

  typedef enum logic [1:0] {
    BCH_FUNC_ENC = 2'b01,
    BCH_FUNC_DEC = 2'b10
  } bch_func_e;

  localparam bch_func_e FUNC_DEFAULT = BCH_FUNC_ENC;
  localparam bch_func_e FUNC_SEL     = BCH_FUNC_DEC;
  localparam logic      CFG_OK       = (FUNC_SEL == BCH_FUNC_DEC) && (M >= M_MIN_DEC) && (M <= M_MAX) &&
                                       (T >= T_MIN_DEC) && (T <= T_MAX_DEC);

  typedef enum logic [2:0] {
    BM_IDLE = 3'b001,
    BM_RUN  = 3'b010,
    BM_DONE = 3'b100
  } bch_bm_e;

  typedef enum logic [2:0] {
    OS_IDLE = 3'b001,
    OS_INIT = 3'b010,
    OS_RUN  = 3'b100
  } bch_out_e;

  localparam bch_sym_t ONE   = 14'h0001;
  localparam bch_sym_t ALPHA = 14'h0002;

  // Multiply by alpha.
  function automatic bch_sym_t xtime(input bch_sym_t a);
    return {a[M-2:0], 1'b0} ^ (a[M-1] ? PRIM_POLY[M-1:0] : '0);
  endfunction : xtime

  function automatic bch_sym_t gf_mul(input bch_sym_t a, input bch_sym_t b);
    bch_sym_t r;
    r = '0;
    for (int i = M - 1; i >= 0; i--) begin
      r = xtime(r) ^ (b[i] ? a : '0);
    end
    return r;
  endfunction : gf_mul

  function automatic bch_sym_t gf_pow(input bch_sym_t a, input logic [M-1:0] e);
    bch_sym_t r;
    bch_sym_t b;
    r = ONE;
    b = a;
    for (int i = 0; i < M; i++) begin
      if (e[i]) begin
        r = gf_mul(r, b);
      end
      b = gf_mul(b, b);
    end
    return r;
  endfunction : gf_pow

  // Locator scale that puts the first received bit at degree N-1.
  localparam bch_sym_t CHIEN_START = gf_pow(ALPHA, M'(GF_ORDER - (N - 1)));

endpackage : bch_pkg

// file: rtl/bch_stream_decoder.sv
// BCH stream decoder: syndromes on input, Berlekamp-Massey, Chien search on output, APB control.
// Behaviour
// R1: A codeword starts with valid and start marker; that word is codeword data.
// R2: Source ends a codeword with end marker; markers last one cycle each.
// R3: While input ready is low no input word is taken.
// R4: Output data is valid only with output valid; first and last word are marked.
// R5: Errors are corrected internally; the error flag marks uncorrectable codewords.
// R6: The whole codeword including check bits is emitted; sink strips them.
// R7: An output reports the number of errors found in the codeword.
// R8: Output start marker is high one cycle, on the first valid word.
// R9: Input ready throttles the source; sink ready low holds the output.
// R10: Source marks exactly the first and last input word of every codeword.
// R11: A word is captured at a rising edge with ready and valid high.
// R12: A build option picks encoder or decoder; encoder is the default pick.
// R13: Symbol width m is 3..14 encoder, 6..14 decoder, default 14.
// R14: Codeword length n runs from parity+1 to 2^m-1, default 8784.
// R15: A new input word is accepted every cycle when 6.5R is below N.
// R16: Correction capacity t is 8..127 for the decoder, default 40.
// R17: Parity bit count derives from t; default gives 560.
// R18: Message length k derives from t and n; default gives 8224.
// R19: Field polynomial follows from m; default value is 17475.
// R20: Parallel width d defaults to 20 within the documented limits.
// R21: All flip-flops use the rising edge of the one clock.
// R22: Reset is active low, asserted asynchronously, released synchronously.
// R23: After reset the source starts with a whole codeword.
// R24: The error count is valid only on the output end-of-packet cycle.
// R25: Correction is guaranteed only up to t bit errors.
module bch_stream_decoder (
  // Clock and reset.
  input  wire logic                   sys_clk_in,
  input  wire logic                   nrst_in,
  // APB register port.
  input  wire logic [7:0]             paddr_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Codeword input stream.
  input  wire logic [bch_pkg::D-1:0]  in_data_in,
  input  wire logic                   in_valid_in,
  input  wire logic                   in_sop_in,
  input  wire logic                   in_eop_in,
  output logic                        in_ready_out,
  // Corrected codeword output stream.
  output logic [bch_pkg::D-1:0]       out_data_out,
  output logic                        out_valid_out,
  output logic                        out_sop_out,
  output logic                        out_eop_out,
  output logic                        out_error_out,
  output logic [bch_pkg::ERRW-1:0]    out_nerr_out,
  input  wire logic                   sink_ready_in
);

  typedef struct packed {
    logic                                        in_act;
    logic [1:0]                                  wr_b;
    logic [1:0]                                  rd_b;
    logic [1:0]                                  full_cnt;
    logic [bch_pkg::WW-1:0]                      wr_word;
    bch_pkg::bch_sym_t [bch_pkg::NSYN-1:0]       syn;
    bch_pkg::bch_bm_e                            bm_st;
    logic [6:0]                                  bm_k;
    bch_pkg::bch_sym_t [bch_pkg::NSYN-1:0]       bm_syn;
    bch_pkg::bch_sym_t [bch_pkg::LEN-1:0]        lam;
    bch_pkg::bch_sym_t [bch_pkg::LEN-1:0]        bb;
    bch_pkg::bch_sym_t                           gam;
    logic [bch_pkg::LW-1:0]                      bm_l;
    bch_pkg::bch_out_e                           o_st;
    logic [bch_pkg::WW-1:0]                      rd_word;
    bch_pkg::bch_sym_t [bch_pkg::LEN-1:0]        term;
    logic [bch_pkg::LW-1:0]                      o_l;
    logic [bch_pkg::ERRW-1:0]                    roots;
    logic [bch_pkg::D-1:0]                       out_data;
    logic                                        out_valid;
    logic                                        out_sop;
    logic                                        out_eop;
    logic                                        out_err;
    logic [bch_pkg::ERRW-1:0]                    out_nerr;
    logic                                        ctrl_corr;
    logic [15:0]                                 stat_cw;
    logic [15:0]                                 stat_bad;
    logic [bch_pkg::ERRW-1:0]                    last_cnt;
    logic                                        last_bad;
    logic [31:0]                                 prdata;
  } bch_state_s;

  bch_state_s                 st_reg;
  bch_state_s                 st_next;
  logic [bch_pkg::D-1:0]      mem [bch_pkg::NBANK*bch_pkg::WORDS];
  logic                       acc;
  logic [bch_pkg::WW-1:0]     wr_idx;
  logic                       apb_acc;
  logic                       apb_hit;

  function automatic logic [bch_pkg::AW-1:0] mem_addr(input logic [1:0] b, input logic [bch_pkg::WW-1:0] w);
    return bch_pkg::AW'(int'(b) * bch_pkg::WORDS + int'(w));
  endfunction : mem_addr

  function automatic logic [1:0] next_bank(input logic [1:0] b);
    return (int'(b) == bch_pkg::NBANK - 1) ? 2'h0 : b + 2'h1;
  endfunction : next_bank

  function automatic int word_bits(input logic [bch_pkg::WW-1:0] w);
    return (int'(w) == bch_pkg::WORDS - 1) ? bch_pkg::REM_BITS : bch_pkg::D; // R14 R17 R18 R19 R20
  endfunction : word_bits

  // Ready needs a free bank, and the last word waits for an idle locator engine.
  assign in_ready_out = (int'(st_reg.full_cnt) < bch_pkg::NBANK) &&                      // R9 R15
                        ((st_reg.bm_st == bch_pkg::BM_IDLE) || (int'(st_reg.wr_word) < bch_pkg::WORDS - 1));
  assign acc          = in_valid_in && in_ready_out && (st_reg.in_act || in_sop_in);   // R1 R3 R11
  assign wr_idx       = in_sop_in ? '0 : st_reg.wr_word;                               // R1

  assign apb_acc     = psel_in && penable_in;
  assign apb_hit     = (paddr_in == bch_pkg::CTRL_OFS) || (paddr_in == bch_pkg::STAT_OFS) ||
                       (paddr_in == bch_pkg::LAST_OFS);
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_acc && !apb_hit;
  assign prdata_out  = st_reg.prdata;

  assign out_data_out  = st_reg.out_data;                                              // R6
  assign out_valid_out = st_reg.out_valid;                                             // R4
  assign out_sop_out   = st_reg.out_sop;
  assign out_eop_out   = st_reg.out_eop;
  assign out_error_out = st_reg.out_err;
  assign out_nerr_out  = st_reg.out_nerr;

  always_comb begin
    bch_pkg::bch_sym_t        s;
    bch_pkg::bch_sym_t        ap;
    bch_pkg::bch_sym_t        dsc;
    bch_pkg::bch_sym_t        bp;
    bch_pkg::bch_sym_t        sum;
    logic [bch_pkg::D-1:0]    word;
    logic [bch_pkg::ERRW-1:0] cnt;
    logic                     cond;
    logic                     inc;
    logic                     dec;
    logic                     bad;
    int                       nbits;
    int                       r;
    s       = '0;
    ap      = '0;
    dsc     = '0;
    bp      = '0;
    sum     = '0;
    word    = '0;
    cnt     = '0;
    cond    = 1'b0;
    inc     = 1'b0;
    dec     = 1'b0;
    bad     = 1'b0;
    nbits   = 0;
    r       = 0;
    st_next = st_reg;

    // Input side: Horner syndrome update, MSB of each word is the earliest bit.
    if (acc) begin
      nbits = word_bits(wr_idx);
      ap    = bch_pkg::ONE;
      for (int j = 0; j < bch_pkg::NSYN; j++) begin
        ap = bch_pkg::xtime(ap);
        s  = in_sop_in ? '0 : st_reg.syn[j];
        for (int i = 0; i < bch_pkg::D; i++) begin
          if (i < nbits) begin
            s = bch_pkg::gf_mul(s, ap) ^ bch_pkg::bch_sym_t'(in_data_in[bch_pkg::D-1-i]);
          end
        end
        st_next.syn[j] = s;
      end
      st_next.in_act  = !in_eop_in;
      st_next.wr_word = wr_idx + 1'b1;
      if (in_eop_in) begin                                                             // R2
        inc           = 1'b1;
        st_next.wr_b  = next_bank(st_reg.wr_b);
        st_next.bm_syn = st_next.syn;
        st_next.bm_st = bch_pkg::BM_RUN;
        st_next.bm_k  = '0;
        st_next.bm_l  = '0;
        st_next.gam   = bch_pkg::ONE;
        st_next.lam   = '0;
        st_next.bb    = '0;
        st_next.lam[0] = bch_pkg::ONE;
        st_next.bb[0]  = bch_pkg::ONE;
      end
    end

    // Inversionless binary Berlekamp-Massey, one syndrome pair per cycle.
    if (st_reg.bm_st == bch_pkg::BM_RUN) begin                                         // R5
      r = 2 * int'(st_reg.bm_k);
      for (int i = 0; i <= bch_pkg::T; i++) begin
        if (i <= r) begin
          dsc = dsc ^ bch_pkg::gf_mul(st_reg.lam[i], st_reg.bm_syn[r-i]);
        end
      end
      cond = (dsc != '0) && (st_reg.bm_l <= bch_pkg::LW'(st_reg.bm_k));
      for (int i = 0; i < bch_pkg::LEN; i++) begin
        st_next.lam[i] = bch_pkg::gf_mul(st_reg.gam, st_reg.lam[i]) ^
                         ((i > 0) ? bch_pkg::gf_mul(dsc, st_reg.bb[i-1]) : '0);
        if (cond) begin
          st_next.bb[i] = (i > 0) ? st_reg.lam[i-1] : '0;
        end else begin
          st_next.bb[i] = (i > 1) ? st_reg.bb[i-2] : '0;
        end
      end
      if (cond) begin
        st_next.bm_l = bch_pkg::LW'(r + 1) - st_reg.bm_l;
        st_next.gam  = dsc;
      end
      st_next.bm_k = st_reg.bm_k + 7'h01;
      if (int'(st_reg.bm_k) == bch_pkg::T - 1) begin
        st_next.bm_st = bch_pkg::BM_DONE;
      end
    end

    // Output side.
    case (st_reg.o_st)
      bch_pkg::OS_IDLE: begin
        if (st_reg.bm_st == bch_pkg::BM_DONE) begin
          st_next.o_st = bch_pkg::OS_INIT;
        end
      end
      bch_pkg::OS_INIT: begin
        bp = bch_pkg::ONE;
        for (int j = 0; j < bch_pkg::LEN; j++) begin
          st_next.term[j] = bch_pkg::gf_mul(st_reg.lam[j], bp);
          bp              = bch_pkg::gf_mul(bp, bch_pkg::CHIEN_START);
        end
        st_next.o_l     = st_reg.bm_l;
        st_next.bm_st   = bch_pkg::BM_IDLE;
        st_next.rd_word = '0;
        st_next.roots   = '0;
        st_next.o_st    = bch_pkg::OS_RUN;
      end
      bch_pkg::OS_RUN: begin
      end
      default: begin
        st_next.o_st = bch_pkg::OS_IDLE;
      end
    endcase

    // A new word is offered only when the register is empty or being taken.
    if (!st_reg.out_valid || sink_ready_in) begin                                      // R9
      if (st_reg.o_st == bch_pkg::OS_RUN) begin
        word  = mem[mem_addr(st_reg.rd_b, st_reg.rd_word)];
        nbits = word_bits(st_reg.rd_word);
        cnt   = st_reg.roots;
        for (int i = 0; i < bch_pkg::D; i++) begin
          if (i < nbits) begin
            sum = '0;
            for (int j = 0; j < bch_pkg::LEN; j++) begin
              sum = sum ^ st_next.term[j];
            end
            if (sum == '0) begin
              if (st_reg.ctrl_corr && bch_pkg::CFG_OK) begin                           // R5 R12 R13 R16
                word[bch_pkg::D-1-i] = !word[bch_pkg::D-1-i];
              end
              if (cnt != '1) begin
                cnt = cnt + 1'b1;                                                      // R7
              end
            end
            ap = bch_pkg::ONE;
            for (int j = 0; j < bch_pkg::LEN; j++) begin
              st_next.term[j] = bch_pkg::gf_mul(st_next.term[j], ap);
              ap              = bch_pkg::xtime(ap);
            end
          end
        end
        // Uncorrectable: locator too long or fewer roots than its degree.
        bad               = (st_reg.o_l > bch_pkg::LW'(bch_pkg::T)) ||
                            (bch_pkg::LW'(cnt) != st_reg.o_l);                         // R25
        st_next.roots     = cnt;
        st_next.out_data  = word;                                                      // R6
        st_next.out_valid = 1'b1;                                                      // R4
        st_next.out_sop   = (st_reg.rd_word == '0);                                    // R8
        st_next.out_eop   = (nbits != bch_pkg::D) || (int'(st_reg.rd_word) == bch_pkg::WORDS - 1);
        st_next.out_err   = st_next.out_eop && bad;                                    // R5
        st_next.out_nerr  = st_next.out_eop ? cnt : '0;                                // R24
        st_next.rd_word   = st_reg.rd_word + 1'b1;
        if (st_next.out_eop) begin
          dec              = 1'b1;
          st_next.rd_b     = next_bank(st_reg.rd_b);
          st_next.o_st     = bch_pkg::OS_IDLE;
          st_next.stat_cw  = st_reg.stat_cw + 16'h0001;
          st_next.stat_bad = st_reg.stat_bad + {15'h0000, bad};
          st_next.last_cnt = cnt;
          st_next.last_bad = bad;
        end
      end else begin
        st_next.out_valid = 1'b0;
        st_next.out_sop   = 1'b0;
        st_next.out_eop   = 1'b0;
        st_next.out_err   = 1'b0;
        st_next.out_nerr  = '0;
      end
    end
    st_next.full_cnt = st_reg.full_cnt + {1'b0, inc} - {1'b0, dec};

    // APB: writes land in the access phase, read data is captured in setup.
    if (apb_acc && pwrite_in && pstrb_in[0] && (paddr_in == bch_pkg::CTRL_OFS)) begin
      st_next.ctrl_corr = pwdata_in[bch_pkg::CTRL_CORR];
    end
    if (psel_in && !penable_in) begin
      st_next.prdata = '0;
      case (paddr_in)
        bch_pkg::CTRL_OFS: st_next.prdata[bch_pkg::CTRL_CORR] = st_reg.ctrl_corr;
        bch_pkg::STAT_OFS: st_next.prdata = {st_reg.stat_bad, st_reg.stat_cw};
        bch_pkg::LAST_OFS: begin
          st_next.prdata[bch_pkg::ERRW-1:0]       = st_reg.last_cnt;
          st_next.prdata[bch_pkg::LAST_BAD_BIT] = st_reg.last_bad;
        end
        default: st_next.prdata = '0;
      endcase
    end
  end

  // Bank memory has no reset; only written words are ever read back.
  always_ff @(posedge sys_clk_in) begin                                                // R21
    if (acc) begin
      mem[mem_addr(st_reg.wr_b, wr_idx)] <= in_data_in;                                // R11
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin                             // R21
    if (!nrst_in) begin                                                                // R22 R23
      st_reg           <= '0;
      st_reg.bm_st     <= bch_pkg::BM_IDLE;
      st_reg.o_st      <= bch_pkg::OS_IDLE;
      st_reg.ctrl_corr <= bch_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : bch_stream_decoder

// file: dv/bch_stream_decoder_checker.sv
// Concurrent assertions on the output stream ports and input ready of the BCH stream decoder.
module bch_checker (
  input wire logic                      sys_clk_in,
  input wire logic                      nrst_in,
  input wire logic                      in_ready_out,
  input wire logic [bch_pkg::D-1:0]     out_data_out,
  input wire logic                      out_valid_out,
  input wire logic                      out_sop_out,
  input wire logic                      out_eop_out,
  input wire logic                      out_error_out,
  input wire logic [bch_pkg::ERRW-1:0]  out_nerr_out,
  input wire logic                      sink_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // Position of the next output word inside its codeword.
  logic [15:0] wcnt_reg;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wcnt_reg <= 16'h0000;
    end else if (out_valid_out && sink_ready_in) begin
      wcnt_reg <= out_eop_out ? 16'h0000 : wcnt_reg + 16'h0001;
    end
  end

  property p_sop_first; out_sop_out |-> out_valid_out && wcnt_reg == 16'h0000; endproperty
  a_sop_first: assert property (p_sop_first) else $error("start marker off the first word");
  property p_eop_last; out_eop_out |-> out_valid_out && wcnt_reg == 16'(bch_pkg::WORDS - 1); endproperty
  a_eop_last: assert property (p_eop_last) else $error("end marker off the last word");
  property p_hold;
    out_valid_out && !sink_ready_in |=> out_valid_out && $stable(out_data_out) && $stable(out_sop_out) &&
      $stable(out_eop_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while sink stalled");
  property p_sop_single; out_valid_out && out_sop_out && sink_ready_in |=> !out_sop_out; endproperty
  a_sop_single: assert property (p_sop_single) else $error("start marker longer than one word");
  property p_nerr_eop; out_nerr_out != '0 |-> out_eop_out && out_valid_out; endproperty
  a_nerr_eop: assert property (p_nerr_eop) else $error("error count outside end word");
  property p_err_eop; out_error_out |-> out_eop_out && out_valid_out; endproperty
  a_err_eop: assert property (p_err_eop) else $error("error flag outside end word");
  property p_nerr_range; out_eop_out && !out_error_out |-> out_nerr_out <= bch_pkg::ERRW'(bch_pkg::T); endproperty
  a_nerr_range: assert property (p_nerr_range) else $error("count above capacity on good word");
  property p_reset_idle; $rose(nrst_in) |-> !out_valid_out ##1 !out_valid_out; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("output valid right after reset");
  property p_reset_ready; $rose(nrst_in) |-> in_ready_out; endproperty
  a_reset_ready: assert property (p_reset_ready) else $error("input not ready after reset");
endmodule : bch_checker

bind bch_stream_decoder bch_checker i_bch_checker (.sys_clk_in, .nrst_in, .in_ready_out, .out_data_out,
  .out_valid_out, .out_sop_out, .out_eop_out, .out_error_out, .out_nerr_out, .sink_ready_in);

// file: dv/bch_sink_model.sv
// Downstream sink model that throttles the decoder output stream.
module bch_sink_model (
  // Clock and reset.
  input  wire logic  sys_clk_in,
  input  wire logic  nrst_in,
  // Stall control.
  input  wire logic  stall_in,
  // Sink handshake.
  output logic       sink_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr_reg;

  // Sink ready is high unless stalled; while stalled it follows bit 0 of the LFSR.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lfsr_reg <= 8'hA5;
      sink_ready_out <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      sink_ready_out <= !stall_in || lfsr_reg[0];
    end
  end
endmodule : bch_sink_model

// file: dv/testbench.sv
// Self-checking testbench for the BCH stream decoder.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = bch_pkg::WORDS;
  logic                      sys_clk_in = 1'b0;
  logic                      nrst_in    = 1'b0;
  logic [7:0]                paddr_in   = 8'h00;
  logic                      psel_in    = 1'b0;
  logic                      penable_in = 1'b0;
  logic                      pwrite_in  = 1'b0;
  logic [31:0]               pwdata_in  = 32'h00000000;
  logic [31:0]               prdata_out;
  logic                      pready_out;
  logic                      pslverr_out;
  logic [bch_pkg::D-1:0]     in_data_in = '0;
  logic                      in_valid_in = 1'b0;
  logic                      in_sop_in  = 1'b0;
  logic                      in_eop_in  = 1'b0;
  logic                      in_ready_out;
  logic [bch_pkg::D-1:0]     out_data_out;
  logic                      out_valid_out;
  logic                      out_sop_out;
  logic                      out_eop_out;
  logic                      out_error_out;
  logic [bch_pkg::ERRW-1:0]  out_nerr_out;
  logic                      sink_ready_in;
  logic                      sink_stall = 1'b0;
  logic [31:0]               seed = 32'h0AFF625D;
  logic [bch_pkg::D-1:0]     exp_q[$];
  logic [bch_pkg::ERRW-1:0]  nerr_q[$];
  int                        fails = 0;
  int                        compares = 0;
  int                        wpos = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  bch_stream_decoder i_bch_stream_decoder (.sys_clk_in, .nrst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
    .pwdata_in, .pstrb_in(4'hF), .prdata_out, .pready_out, .pslverr_out, .in_data_in, .in_valid_in, .in_sop_in,
    .in_eop_in, .in_ready_out, .out_data_out, .out_valid_out, .out_sop_out, .out_eop_out, .out_error_out,
    .out_nerr_out, .sink_ready_in);
  bch_sink_model i_bch_sink_model (.sys_clk_in, .nrst_in, .stall_in(sink_stall), .sink_ready_out(sink_ready_in));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp,
                     input logic exp_err);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_out !== 1'b1 && n < 100) begin
      n++;
      @(posedge sys_clk_in);
    end
    if (n >= 100) fails++;
    if (!wr) chk("prdata", exp, prdata_out);
    chk("pslverr", 32'(exp_err), 32'(pslverr_out));
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : apb

  // Sends an all-zero codeword with ne bit errors in distinct words, plus raw filler in the unused tail.
  task automatic send_cw(input int ne, input logic fix);
    logic [bch_pkg::D-1:0] cw [W];
    int n;
    for (int i = 0; i < W; i++) cw[i] = '0;
    for (int e = 0; e < ne; e++) cw[e * 10 + xs() % 10][xs() % 20] ^= 1'b1;
    cw[W-1][15:0] = xs();
    for (int i = 0; i < W; i++) exp_q.push_back(fix ? ((i == W - 1) ? (cw[i] & 20'h0FFFF) : '0) : cw[i]);
    nerr_q.push_back(bch_pkg::ERRW'(ne));
    for (int i = 0; i < W; i++) begin
      if (xs() % 8 == 0) begin
        in_valid_in <= 1'b0;
        in_data_in <= bch_pkg::D'(xs());
        @(posedge sys_clk_in);
      end
      in_valid_in <= 1'b1;
      in_sop_in <= (i == 0);
      in_eop_in <= (i == W - 1);
      in_data_in <= cw[i];
      n = 0;
      @(posedge sys_clk_in);
      while (in_ready_out !== 1'b1 && n < 5000) begin
        n++;
        @(posedge sys_clk_in);
      end
      if (n >= 5000) fails++;
    end
    in_valid_in <= 1'b0;
    in_sop_in <= 1'b0;
    in_eop_in <= 1'b0;
    in_data_in <= bch_pkg::D'(xs());
    @(posedge sys_clk_in);
  endtask : send_cw

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 20000) begin
      n++;
      @(posedge sys_clk_in);
    end
    chk("drain", 32'h0, 32'(exp_q.size()));
  endtask : drain

  always @(posedge sys_clk_in) begin
    if (nrst_in && out_valid_out === 1'b1 && sink_ready_in === 1'b1) begin
      chk("out_sop", 32'(wpos == 0), 32'(out_sop_out));
      chk("out_data", 32'(exp_q.pop_front()), 32'(out_data_out));
      wpos++;
      chk("out_eop", 32'(wpos == W), 32'(out_eop_out));
      if (wpos == W) begin
        chk("out_nerr", 32'(nerr_q.pop_front()), 32'(out_nerr_out));
        chk("out_error", 32'h0, 32'(out_error_out));
        wpos = 0;
      end
    end
  end

  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    #500000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    apb(1'b0, bch_pkg::CTRL_OFS, 32'h0, 32'h1, 1'b0);
    send_cw(0, 1'b1);
    sink_stall <= 1'b1;
    send_cw(40, 1'b1);
    send_cw(1, 1'b1);
    drain();
    apb(1'b0, bch_pkg::STAT_OFS, 32'h0, 32'h3, 1'b0);
    apb(1'b1, bch_pkg::STAT_OFS, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b0, bch_pkg::STAT_OFS, 32'h0, 32'h3, 1'b0);
    apb(1'b0, bch_pkg::LAST_OFS, 32'h0, 32'h1, 1'b0);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
    apb(1'b1, bch_pkg::CTRL_OFS, 32'h0, 32'h0, 1'b0);
    send_cw(5, 1'b0);
    drain();
    apb(1'b0, bch_pkg::LAST_OFS, 32'h0, 32'h5, 1'b0);
    send_cw(3, 1'b0);
    while (out_valid_out !== 1'b1) @(posedge sys_clk_in);
    nrst_in <= 1'b0;
    @(posedge sys_clk_in);
    chk("reset valid", 32'h0, 32'(out_valid_out));
    exp_q.delete();
    nerr_q.delete();
    wpos = 0;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    send_cw(2, 1'b1);
    drain();
    apb(1'b0, bch_pkg::STAT_OFS, 32'h0, 32'h1, 1'b0);
    wrap_up();
  end
endmodule : testbench
